/* include/snsi_pkg.sv */
// Contract
// - seventeen 8-bit registers hold control, setup and measurement results
// - register addresses 0x80 to 0x90 select consecutive registers
// - device answers only the fixed 7-bit slave address 0x13
// - serial port works at standard, fast and high-speed bit rates
// - all registers reached only over the serial port; writes to 0x81 and 0x85 to 0x88 are ignored
// - command register 0x80 starts measurements and holds two ready flags
// - light-ready flag sets on new light result, clears on reading 5 or 6
// - near-ready flag sets on new near result, clears on reading 7 or 8
// - writing one to light single-shot bit starts one light measurement
// - with averaging on, light single shot averages several readings into result
// - light result high byte in register five, low byte in register six
// - interrupt output only pulls low or releases, open drain
// - light periodic enable repeats light measurements while self-timed runs
// - near periodic enable repeats near measurements at programmed rate while self-timed runs
// - self-timed enable starts timing but measures only with periodic enable
// - while self-timed is set, single-shot requests are ignored
package snsi_pkg;
    localparam logic [6:0] SLV_ADDR = 7'h13;
    localparam int NUM_REGS = 17;
    localparam logic [7:0] REG_BASE = 8'h80;
    localparam logic [7:0] REG_LAST = 8'h90;
    // register indices (address minus base)
    localparam logic [4:0] IDX_CMD = 5'h00;
    localparam logic [4:0] IDX_ID = 5'h01;
    localparam logic [4:0] IDX_NRATE = 5'h02;
    localparam logic [4:0] IDX_LCFG = 5'h04;
    localparam logic [4:0] IDX_LHI = 5'h05;
    localparam logic [4:0] IDX_LLO = 5'h06;
    localparam logic [4:0] IDX_NHI = 5'h07;
    localparam logic [4:0] IDX_NLO = 5'h08;
    localparam logic [4:0] IDX_INTCTL = 5'h09;
    // command register fields
    localparam int CMD_LOCK = 7;
    localparam int CMD_LRDY = 6;
    localparam int CMD_NRDY = 5;
    localparam int CMD_LOD = 4;
    localparam int CMD_NOD = 3;
    localparam int CMD_LPER = 2;
    localparam int CMD_NPER = 1;
    localparam int CMD_ST = 0;
    // light config fields: rate in [6:4], averaging log2 in [2:0]
    localparam int LCFG_RATE_LSB = 4;
    localparam int LCFG_AVG_LSB = 0;
    // interrupt control fields
    localparam int INT_LEN = 0;
    localparam int INT_NEN = 1;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [2:0] CTL_RST = 3'h0;
    localparam int SYNC_STAGES = 3;
    // timing
    localparam int CLK_NS = 8;
    localparam int CONV_US = 10;
    localparam int CONV_CYC = (CONV_US * 1000) / CLK_NS;
    localparam int TICK_US = 4000;
    localparam int TICK_CYC = (TICK_US * 1000) / CLK_NS;

    typedef struct packed {
        logic [15:0] light;
        logic [15:0] near;
    } snsi_res_t;

    typedef struct packed {
        logic st_en;
        logic light_per;
        logic near_per;
        logic light_od;
        logic near_od;
        logic [2:0] near_rate;
        logic [2:0] light_rate;
        logic [2:0] avg_log2;
    } snsi_ctl_t;

    typedef enum logic [3:0] {
        SI_IDLE = 4'b0000,
        SI_ADDR = 4'b0001,
        SI_AACK = 4'b0010,
        SI_REG = 4'b0011,
        SI_RACK = 4'b0100,
        SI_WDAT = 4'b0101,
        SI_WACK = 4'b0110,
        SI_TX = 4'b0111,
        SI_MACK = 4'b1000
    } snsi_bus_st_t;

    typedef enum logic [1:0] {
        SM_IDLE = 2'b00,
        SM_LIGHT = 2'b01,
        SM_NEAR = 2'b10
    } snsi_meas_st_t;

    // periodic interval in ticks for a 3-bit rate code
    function automatic logic [7:0] rate_ticks(input logic [2:0] r);
        rate_ticks = 8'h01 << (3'h7 - r);
    endfunction
endpackage

/* verilog/snsi_meas.sv */
module snsi_meas #(
    parameter int CONV_CYCLES = snsi_pkg::CONV_CYC,
    parameter int TICK_CYCLES = snsi_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // control from command, near rate and light config registers
    input wire snsi_pkg::snsi_ctl_t ctl,
    // front-end samples
    input wire logic [15:0] light_sample,
    input wire logic [15:0] near_sample,
    // results
    output snsi_pkg::snsi_res_t res,
    output logic light_done,
    output logic near_done,
    output logic light_busy,
    output logic near_busy
);
    import snsi_pkg::*;

    snsi_meas_st_t st_ff, nxt_st;
    logic [31:0] tick_ff, nxt_tick;
    logic [7:0] lcnt_ff, nxt_lcnt, ncnt_ff, nxt_ncnt;
    logic lpend_ff, nxt_lpend, npend_ff, nxt_npend;
    logic [31:0] cyc_ff, nxt_cyc;
    logic [7:0] nsamp_ff, nxt_nsamp;
    logic [23:0] acc_ff, nxt_acc;
    snsi_res_t res_ff, nxt_res;
    logic ldone_ff, nxt_ldone, ndone_ff, nxt_ndone;

    always_comb begin
        logic tick;
        logic [23:0] sum;
        tick = 1'b0;
        sum = 24'h000000;
        nxt_st = st_ff;
        nxt_tick = tick_ff;
        nxt_lcnt = lcnt_ff;
        nxt_ncnt = ncnt_ff;
        nxt_lpend = lpend_ff;
        nxt_npend = npend_ff;
        nxt_cyc = cyc_ff;
        nxt_nsamp = nsamp_ff;
        nxt_acc = acc_ff;
        nxt_res = res_ff;
        nxt_ldone = 1'b0;
        nxt_ndone = 1'b0;
        // self-timed base only runs with its enable
        if (ctl.st_en) begin
            tick = (tick_ff == 32'(TICK_CYCLES - 1));
            nxt_tick = tick ? 32'h0 : tick_ff + 32'h1;
        end else begin
            nxt_tick = 32'h0;
            nxt_lcnt = 8'h00;
            nxt_ncnt = 8'h00;
        end
        if (tick && ctl.light_per) begin
            if (lcnt_ff >= rate_ticks(ctl.light_rate) - 8'h01) begin
                nxt_lcnt = 8'h00;
                nxt_lpend = 1'b1;
            end else begin
                nxt_lcnt = lcnt_ff + 8'h01;
            end
        end
        if (tick && ctl.near_per) begin
            if (ncnt_ff >= rate_ticks(ctl.near_rate) - 8'h01) begin
                nxt_ncnt = 8'h00;
                nxt_npend = 1'b1;
            end else begin
                nxt_ncnt = ncnt_ff + 8'h01;
            end
        end
        // on-demand requests only without self-timed mode
        if (!ctl.st_en && ctl.light_od) begin
            nxt_lpend = 1'b1;
        end
        if (!ctl.st_en && ctl.near_od) begin
            nxt_npend = 1'b1;
        end
        case (st_ff)
            SM_IDLE: begin
                nxt_cyc = 32'h0;
                nxt_nsamp = 8'h00;
                nxt_acc = 24'h000000;
                // light goes first when both are asked together
                if (lpend_ff) begin
                    nxt_lpend = 1'b0;
                    nxt_st = SM_LIGHT;
                end else if (npend_ff) begin
                    nxt_npend = 1'b0;
                    nxt_st = SM_NEAR;
                end
            end
            SM_LIGHT: begin
                nxt_cyc = cyc_ff + 32'h1;
                if (cyc_ff == 32'(CONV_CYCLES - 1)) begin
                    nxt_cyc = 32'h0;
                    sum = acc_ff + {8'h00, light_sample};
                    nxt_acc = sum;
                    nxt_nsamp = nsamp_ff + 8'h01;
                    // average over 2^n readings, keep only the mean
                    if (nxt_nsamp == (8'h01 << ctl.avg_log2)) begin
                        nxt_res.light = 16'(sum >> ctl.avg_log2);
                        nxt_ldone = 1'b1;
                        nxt_st = SM_IDLE;
                    end
                end
            end
            SM_NEAR: begin
                nxt_cyc = cyc_ff + 32'h1;
                if (cyc_ff == 32'(CONV_CYCLES - 1)) begin
                    nxt_res.near = near_sample;
                    nxt_ndone = 1'b1;
                    nxt_st = SM_IDLE;
                end
            end
            default: nxt_st = SM_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= SM_IDLE;
            tick_ff <= 32'h0;
            lcnt_ff <= 8'h00;
            ncnt_ff <= 8'h00;
            lpend_ff <= 1'b0;
            npend_ff <= 1'b0;
            cyc_ff <= 32'h0;
            nsamp_ff <= 8'h00;
            acc_ff <= 24'h000000;
            res_ff <= '0;
            ldone_ff <= 1'b0;
            ndone_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            tick_ff <= nxt_tick;
            lcnt_ff <= nxt_lcnt;
            ncnt_ff <= nxt_ncnt;
            lpend_ff <= nxt_lpend;
            npend_ff <= nxt_npend;
            cyc_ff <= nxt_cyc;
            nsamp_ff <= nxt_nsamp;
            acc_ff <= nxt_acc;
            res_ff <= nxt_res;
            ldone_ff <= nxt_ldone;
            ndone_ff <= nxt_ndone;
        end
    end

    assign res = res_ff;
    assign light_done = ldone_ff;
    assign near_done = ndone_ff;
    assign light_busy = lpend_ff | (st_ff == SM_LIGHT);
    assign near_busy = npend_ff | (st_ff == SM_NEAR);
endmodule // snsi_meas

/* verilog/snsi_top.sv */
module snsi_top #(
    parameter int CONV_CYCLES = snsi_pkg::CONV_CYC,
    parameter int TICK_CYCLES = snsi_pkg::TICK_CYC,
    parameter logic [7:0] ID_VALUE = 8'h5a // arbitrary
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oen,
    // interrupt pin, open drain
    output logic int_o,
    output logic int_oen,
    // front-end samples
    input wire logic [15:0] light_sample,
    input wire logic [15:0] near_sample
);
    import snsi_pkg::*;

    // three-stage synchronisers, levels move once stages 2 and 3 agree
    logic [SYNC_STAGES-1:0] scl_sync_ff, nxt_scl_sync;
    logic [SYNC_STAGES-1:0] sda_sync_ff, nxt_sda_sync;
    logic scl_lv_ff, nxt_scl_lv, sda_lv_ff, nxt_sda_lv;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        nxt_scl_sync = {scl_sync_ff[SYNC_STAGES-2:0], scl_i};
        nxt_sda_sync = {sda_sync_ff[SYNC_STAGES-2:0], sda_i};
        nxt_scl_lv = scl_lv_ff;
        nxt_sda_lv = sda_lv_ff;
        if (scl_sync_ff[1] == scl_sync_ff[2]) begin
            nxt_scl_lv = scl_sync_ff[2];
        end
        if (sda_sync_ff[1] == sda_sync_ff[2]) begin
            nxt_sda_lv = sda_sync_ff[2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            scl_sync_ff <= '1;
            sda_sync_ff <= '1;
            scl_lv_ff <= 1'b1;
            sda_lv_ff <= 1'b1;
        end else begin
            scl_sync_ff <= nxt_scl_sync;
            sda_sync_ff <= nxt_sda_sync;
            scl_lv_ff <= nxt_scl_lv;
            sda_lv_ff <= nxt_sda_lv;
        end
    end

    // edges on the filtered levels; clock sampling sets the top bit rate
    assign scl_rise = nxt_scl_lv & ~scl_lv_ff;
    assign scl_fall = ~nxt_scl_lv & scl_lv_ff;
    assign start_det = scl_lv_ff & nxt_scl_lv & sda_lv_ff & ~nxt_sda_lv;
    assign stop_det = scl_lv_ff & nxt_scl_lv & ~sda_lv_ff & nxt_sda_lv;

    // register bank
    logic [7:0] regs_ff [NUM_REGS];
    logic [7:0] nxt_regs [NUM_REGS];
    logic [2:0] ctl_ff, nxt_ctl;
    logic lod_ff, nxt_lod, nod_ff, nxt_nod;
    logic lrdy_ff, nxt_lrdy, nrdy_ff, nxt_nrdy;
    logic wr_stb, rd_stb;
    logic [7:0] wr_addr, wr_data, rd_addr;
    snsi_ctl_t ctl;
    snsi_res_t res;
    logic light_done, near_done, light_busy, near_busy;

    // inside the bank, index is address minus base
    function automatic logic in_bank(input logic [7:0] a);
        in_bank = (a >= REG_BASE) && (a <= REG_LAST);
    endfunction

    function automatic logic [4:0] reg_idx(input logic [7:0] a);
        reg_idx = 5'(a - REG_BASE);
    endfunction

    logic [7:0] cmd_view;
    assign cmd_view = {1'b1, lrdy_ff, nrdy_ff, light_busy, near_busy,
        ctl_ff};

    function automatic logic [7:0] read_reg(input logic [7:0] a,
        input logic [7:0] cmd, input snsi_res_t r,
        input logic [7:0] gen);
        read_reg = 8'h00;
        if (in_bank(a)) begin
            case (reg_idx(a))
                IDX_CMD: read_reg = cmd;
                IDX_ID: read_reg = ID_VALUE;
                IDX_LHI: read_reg = r.light[15:8];
                IDX_LLO: read_reg = r.light[7:0];
                IDX_NHI: read_reg = r.near[15:8];
                IDX_NLO: read_reg = r.near[7:0];
                default: read_reg = gen;
            endcase
        end
    endfunction

    always_comb begin
        logic [4:0] wi;
        logic [4:0] ri;
        wi = reg_idx(wr_addr);
        ri = reg_idx(rd_addr);
        nxt_regs = regs_ff;
        nxt_ctl = ctl_ff;
        nxt_lod = 1'b0;
        nxt_nod = 1'b0;
        nxt_lrdy = lrdy_ff;
        nxt_nrdy = nrdy_ff;
        // only the serial port writes the bank
        if (wr_stb && in_bank(wr_addr)) begin
            case (wi)
                IDX_CMD: begin
                    nxt_ctl = wr_data[2:0];
                    nxt_lod = wr_data[CMD_LOD];
                    nxt_nod = wr_data[CMD_NOD];
                end
                IDX_ID, IDX_LHI, IDX_LLO, IDX_NHI, IDX_NLO: begin
                    nxt_ctl = ctl_ff;
                end
                default: nxt_regs[wi] = wr_data;
            endcase
        end
        // clear on read of a result byte; a new result wins
        if (rd_stb && in_bank(rd_addr)) begin
            if (ri == IDX_LHI || ri == IDX_LLO) begin
                nxt_lrdy = 1'b0;
            end
            if (ri == IDX_NHI || ri == IDX_NLO) begin
                nxt_nrdy = 1'b0;
            end
        end
        if (light_done) begin
            nxt_lrdy = 1'b1;
        end
        if (near_done) begin
            nxt_nrdy = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= REG_RST;
            end
            ctl_ff <= CTL_RST;
            lod_ff <= 1'b0;
            nod_ff <= 1'b0;
            lrdy_ff <= 1'b0;
            nrdy_ff <= 1'b0;
        end else begin
            regs_ff <= nxt_regs;
            ctl_ff <= nxt_ctl;
            lod_ff <= nxt_lod;
            nod_ff <= nxt_nod;
            lrdy_ff <= nxt_lrdy;
            nrdy_ff <= nxt_nrdy;
        end
    end

    always_comb begin
        ctl.st_en = ctl_ff[CMD_ST];
        ctl.light_per = ctl_ff[CMD_LPER];
        ctl.near_per = ctl_ff[CMD_NPER];
        ctl.light_od = lod_ff;
        ctl.near_od = nod_ff;
        ctl.near_rate = regs_ff[IDX_NRATE][2:0];
        ctl.light_rate = regs_ff[IDX_LCFG][LCFG_RATE_LSB +: 3];
        ctl.avg_log2 = regs_ff[IDX_LCFG][LCFG_AVG_LSB +: 3];
    end

    snsi_meas #(
        .CONV_CYCLES(CONV_CYCLES),
        .TICK_CYCLES(TICK_CYCLES)
    ) u_meas (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ctl(ctl),
        .light_sample(light_sample),
        .near_sample(near_sample),
        .res(res),
        .light_done(light_done),
        .near_done(near_done),
        .light_busy(light_busy),
        .near_busy(near_busy)
    );

    // serial slave
    snsi_bus_st_t st_ff, nxt_st;
    logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr;
    logic [3:0] bit_ff, nxt_bit;
    logic rw_ff, nxt_rw, pull_ff, nxt_pull;
    logic [7:0] tx_byte;

    assign tx_byte = read_reg(ptr_ff, cmd_view, res, regs_ff[reg_idx(ptr_ff)]);

    always_comb begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_ptr = ptr_ff;
        nxt_bit = bit_ff;
        nxt_rw = rw_ff;
        nxt_pull = pull_ff;
        wr_stb = 1'b0;
        wr_addr = ptr_ff;
        wr_data = sh_ff;
        rd_stb = 1'b0;
        rd_addr = ptr_ff;
        if (stop_det) begin
            nxt_st = SI_IDLE;
            nxt_pull = 1'b0;
        end else if (start_det) begin
            nxt_st = SI_ADDR;
            nxt_bit = 4'h0;
            nxt_pull = 1'b0;
        end else if (scl_rise) begin
            case (st_ff)
                SI_ADDR, SI_REG, SI_WDAT: begin
                    nxt_sh = {sh_ff[6:0], sda_lv_ff};
                    nxt_bit = bit_ff + 4'h1;
                end
                SI_MACK: if (sda_lv_ff) nxt_st = SI_IDLE;
                default: nxt_st = st_ff;
            endcase
        end else if (scl_fall) begin
            case (st_ff)
                SI_ADDR: if (bit_ff == 4'h8) begin
                    // fixed address; low bit picks the direction
                    if (sh_ff[7:1] == SLV_ADDR) begin
                        nxt_rw = sh_ff[0];
                        nxt_pull = 1'b1;
                        nxt_st = SI_AACK;
                    end else begin
                        nxt_st = SI_IDLE;
                    end
                end
                SI_AACK, SI_MACK: begin
                    if (rw_ff || st_ff == SI_MACK) begin
                        nxt_sh = {tx_byte[6:0], 1'b0};
                        nxt_pull = ~tx_byte[7];
                        nxt_bit = 4'h1;
                        rd_stb = 1'b1;
                        nxt_ptr = ptr_ff + 8'h01;
                        nxt_st = SI_TX;
                    end else begin
                        nxt_pull = 1'b0;
                        nxt_bit = 4'h0;
                        nxt_st = SI_REG;
                    end
                end
                SI_REG: if (bit_ff == 4'h8) begin
                    nxt_ptr = sh_ff;
                    nxt_pull = 1'b1;
                    nxt_st = SI_RACK;
                end
                SI_WDAT: if (bit_ff == 4'h8) begin
                    wr_stb = 1'b1;
                    nxt_ptr = ptr_ff + 8'h01;
                    nxt_pull = 1'b1;
                    nxt_st = SI_WACK;
                end
                SI_RACK, SI_WACK: begin
                    nxt_pull = 1'b0;
                    nxt_bit = 4'h0;
                    nxt_st = SI_WDAT;
                end
                SI_TX: begin
                    if (bit_ff == 4'h8) begin
                        nxt_pull = 1'b0;
                        nxt_st = SI_MACK;
                    end else begin
                        nxt_pull = ~sh_ff[7];
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_bit = bit_ff + 4'h1;
                    end
                end
                default: nxt_st = st_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= SI_IDLE;
            sh_ff <= REG_RST;
            ptr_ff <= REG_BASE;
            bit_ff <= 4'h0;
            rw_ff <= 1'b0;
            pull_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            ptr_ff <= nxt_ptr;
            bit_ff <= nxt_bit;
            rw_ff <= nxt_rw;
            pull_ff <= nxt_pull;
        end
    end

    // interrupt only ever pulls low
    logic int_pull_ff, nxt_int_pull;
    always_comb begin
        nxt_int_pull = (lrdy_ff & regs_ff[IDX_INTCTL][INT_LEN]) |
            (nrdy_ff & regs_ff[IDX_INTCTL][INT_NEN]);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            int_pull_ff <= 1'b0;
        end else begin
            int_pull_ff <= nxt_int_pull;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oen = ~pull_ff;
    assign int_o = 1'b0;
    assign int_oen = ~int_pull_ff;
endmodule // snsi_top

/* verif/snsi_checker.sv */
module snsi_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oen,
    // interrupt pin
    input wire logic int_o,
    input wire logic int_oen
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_sda_value_low: assert property (sda_o == 1'b0)
        else $error("sda_o driven high");
    a_int_value_low: assert property (int_o == 1'b0)
        else $error("int_o driven high");
    a_reset_idle: assert property ($rose(rstn) |-> sda_oen && int_oen)
        else $error("pins not released after reset");
    // pulling only after the synchroniser has seen scl low
    a_pull_scl_low: assert property ($fell(sda_oen) |-> !scl_i && !$past(scl_i, 3))
        else $error("sda pull begins outside scl low");
    a_hold_scl_high: assert property ($rose(scl_i) && !sda_oen |=> !sda_oen [*3])
        else $error("sda pull dropped while scl high");
    a_no_fake_start: assert property ($fell(sda_i) && scl_i |-> sda_oen)
        else $error("device made a start condition");
    a_release_scl_low: assert property ($rose(sda_oen) |-> !scl_i)
        else $error("sda released while scl high");
    a_fall_latency: assert property ($fell(scl_i) |-> ##1 $stable(sda_oen) [*2])
        else $error("sda changed before scl fall was filtered");
    // clearing comes from a bus access, which lands at an scl low phase
    a_int_clear_bus: assert property ($rose(int_oen) |-> !scl_i)
        else $error("interrupt released outside bus access");

    c_ack: cover property ($fell(sda_oen));
    c_int_set: cover property ($fell(int_oen));
    c_int_clr: cover property ($rose(int_oen));
endmodule // snsi_checker

bind snsi_top snsi_checker chk (.ref_clk(ref_clk), .rstn(rstn), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oen(sda_oen), .int_o(int_o),
    .int_oen(int_oen));

/* verif/snsi_host.sv */
module snsi_host (
    // clock
    input wire logic ref_clk,
    // bus
    input wire logic sda_oen,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b1;
    initial scl = 1'b1;
    // wired-and with pull-up: released line reads high
    assign sda = drv & sda_oen;

    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // 20 cycles per bit gives the 160 ns serial clock
    task automatic bit_io(input logic b, output logic r);
        drv <= b;
        w(5);
        scl <= 1'b1;
        w(5);
        r = sda;
        w(5);
        scl <= 1'b0;
        w(5);
    endtask
    task automatic start();
        drv <= 1'b1;
        w(5);
        scl <= 1'b1;
        w(10);
        drv <= 1'b0;
        w(10);
        scl <= 1'b0;
        w(5);
    endtask
    task automatic stop();
        drv <= 1'b0;
        w(5);
        scl <= 1'b1;
        w(10);
        drv <= 1'b1;
        w(10);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic probe(input logic [7:0] b, output logic ack);
        start();
        put(b, ack);
        stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        start();
        put(8'h26, k);
        put(a, k);
        put(d, k);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic k;
        logic r;
        start();
        put(8'h26, k);
        put(a, k);
        start();
        put(8'h27, k);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
        stop();
    endtask
endmodule // snsi_host

/* verif/testbench.sv */
module testbench;
    import snsi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] lsmp = 16'hbeef;
    logic [15:0] nsmp = 16'h0c35;
    logic scl, sda, sda_o, sda_oen, int_o, int_oen;
    logic [7:0] d;
    logic k;
    int error_cnt = 0;
    int checked = 0;

    initial forever #4 ref_clk = ~ref_clk;

    snsi_top #(.CONV_CYCLES(4), .TICK_CYCLES(20), .ID_VALUE(8'h3c)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oen(sda_oen), .int_o(int_o), .int_oen(int_oen),
        .light_sample(lsmp), .near_sample(nsmp));
    snsi_host host (.ref_clk(ref_clk), .sda_oen(sda_oen), .scl(scl),
        .sda(sda));

    task automatic conclude();
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e,
        input logic [7:0] m);
        host.rd(a, d);
        chk($sformatf("reg %h", a), e, d & m);
    endtask
    task automatic wait_int();
        int n;
        n = 0;
        while (int_oen !== 1'b0 && n < 6000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("int_oen low", 8'h00, {7'h0, int_oen});
        if (n >= 6000) conclude();
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        host.w(8);
        chk("int_oen idle", 8'h01, {7'h0, int_oen});
        host.probe(8'h24, k);
        chk("foreign addr ack", 8'h00, {7'h0, k});
        host.probe(8'h26, k);
        chk("own addr ack", 8'h01, {7'h0, k});
        rchk(8'h80, 8'h80, 8'hff);
        rchk(8'h81, 8'h3c, 8'hff);
        rchk(8'h91, 8'h00, 8'hff);
        for (int i = 10; i <= 16; i++) host.wr(8'(8'h80 + i), 8'(8'ha0 + i));
        for (int i = 10; i <= 16; i++) rchk(8'(8'h80 + i), 8'(8'ha0 + i), 8'hff);
        host.wr(8'h89, 8'h01);
        for (int v = 0; v < 2; v++) begin
            lsmp <= v ? 16'h1234 : 16'hbeef;
            host.wr(8'h84, 8'(v));
            host.wr(8'h80, 8'h10);
            wait_int();
            rchk(8'h80, 8'hc0, 8'hff);
            rchk(8'h85, v ? 8'h12 : 8'hbe, 8'hff);
            rchk(8'h86, v ? 8'h34 : 8'hef, 8'hff);
            rchk(8'h80, 8'h80, 8'hff);
            chk("int_oen clear", 8'h01, {7'h0, int_oen});
        end
        host.wr(8'h89, 8'h02);
        host.wr(8'h80, 8'h08);
        wait_int();
        rchk(8'h80, 8'ha0, 8'hff);
        rchk(8'h87, 8'h0c, 8'hff);
        rchk(8'h88, 8'h35, 8'hff);
        rchk(8'h80, 8'h80, 8'hff);
        host.wr(8'h80, 8'h01);
        host.w(300);
        rchk(8'h80, 8'h81, 8'hff);
        host.wr(8'h80, 8'h19);
        rchk(8'h80, 8'h81, 8'hff);
        chk("int_oen ignored", 8'h01, {7'h0, int_oen});
        // rates only change while self-timed is off
        host.wr(8'h80, 8'h00);
        host.wr(8'h84, 8'h00);
        host.wr(8'h82, 8'h00);
        host.wr(8'h89, 8'h01);
        host.wr(8'h80, 8'h05);
        wait_int();
        rchk(8'h80, 8'h40, 8'h40);
        rchk(8'h85, 8'h12, 8'hff);
        chk("int_oen cleared", 8'h01, {7'h0, int_oen});
        wait_int();
        host.wr(8'h80, 8'h00);
        host.wr(8'h89, 8'h02);
        host.wr(8'h80, 8'h03);
        wait_int();
        rchk(8'h80, 8'h20, 8'h20);
        conclude();
    end
endmodule // testbench
